// >>> piu_consts.vh
`ifndef PIU_CONSTS_VH
`define PIU_CONSTS_VH
// ----------------------------------------------------------------
// register map (byte addresses on the axi4-lite bus)
// ----------------------------------------------------------------
`define PIU_ADDR_OPTION 8'hc8
`define PIU_ADDR_STATUS 8'hcc
`define PIU_ADDR_CORE 8'hd0
`define PIU_ADDR_EVENT 8'hd4
`define PIU_OPTION_RESET 8'h00
// ----------------------------------------------------------------
// option register fields
// ----------------------------------------------------------------
`define PIU_BIT_LEVEL_SEL 6
`define PIU_BIT_EDGE_POL 5
`define PIU_BIT_GLOBAL_EN 4
`define PIU_OPTION_MASK 8'h70
// ----------------------------------------------------------------
// vector addresses (12-bit program space)
// ----------------------------------------------------------------
`define PIU_VEC_NMI 12'hffc
`define PIU_VEC_SRC1 12'hff6
`define PIU_VEC_SRC2 12'hff4
`define PIU_VEC_SRC3 12'hff2
`define PIU_VEC_SRC4 12'hff0
// ----------------------------------------------------------------
// misc
// ----------------------------------------------------------------
`define PIU_RESP_OKAY 2'b00
`define PIU_RESP_SLVERR 2'b10
`define PIU_LDI_WINDOW 3'h3
`endif

// >>> piu_prioritized_interrupt_unit.v
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "piu_consts.vh"
module piu_prioritized_interrupt_unit #(
  parameter integer PC_W = 12,
  parameter integer EV_W = 4
) (
  input wire aclk,
  input wire aresetn,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // request pins and peripheral events (asynchronous)
  input wire nmi_pin,
  input wire [EV_W-1:0] src1_events,
  input wire [EV_W-1:0] src2_events,
  input wire [EV_W-1:0] src3_events,
  input wire [EV_W-1:0] src4_events,
  // core sequencer side
  input wire instr_end,
  input wire option_ldi_active,
  input wire [2:0] option_ldi_cycle,
  input wire return_from_irq_instr,
  input wire core_sleeping,
  input wire [PC_W-1:0] core_pc,
  input wire carry_in,
  input wire zero_in,
  output reg irq_take,
  output reg [PC_W-1:0] vector_addr,
  output reg stack_push,
  output reg [PC_W-1:0] stack_push_pc,
  output reg stack_pop,
  output reg wake_up,
  output wire carry_flag,
  output wire zero_flag,
  output wire [1:0] flag_set
);
  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  localparam integer SW = 1 + 4 * EV_W;
  wire [SW-1:0] raw_in = {src4_events, src3_events, src2_events, src1_events, nmi_pin};
  // reset to the idle high level, so no false edge follows reset
  reg [SW-1:0] sync1_q;
  reg [SW-1:0] sync2_q;
  reg [SW-1:0] prev_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= {SW{1'b1}};
      sync2_q <= {SW{1'b1}};
      prev_q <= {SW{1'b1}};
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  // events are active low; each source is the and of its ored lines
  wire nmi_s = sync2_q[0];
  wire nmi_prev = prev_q[0];
  wire s1 = &sync2_q[EV_W:1];
  wire s2 = &sync2_q[2*EV_W:EV_W+1];
  wire s3 = &sync2_q[3*EV_W:2*EV_W+1];
  wire s4 = &sync2_q[4*EV_W:3*EV_W+1];
  wire s1_p = &prev_q[EV_W:1];
  wire s2_p = &prev_q[2*EV_W:EV_W+1];

  // ----------------------------------------------------------------
  // option register
  // ----------------------------------------------------------------
  reg [7:0] option_q;
  wire src1_level_select = option_q[`PIU_BIT_LEVEL_SEL];
  wire src2_edge_polarity = option_q[`PIU_BIT_EDGE_POL];
  wire global_irq_enable = option_q[`PIU_BIT_GLOBAL_EN];

  // ----------------------------------------------------------------
  // request latches
  // ----------------------------------------------------------------
  localparam [1:0] MODE_NORM = 2'b00;
  localparam [1:0] MODE_IRQ = 2'b01;
  localparam [1:0] MODE_NMI = 2'b10;
  reg nmi_latch_q;
  reg s1_latch_q;
  reg s2_latch_q;
  reg [SW-2:0] event_flags_q;
  reg in_irq_q;
  reg in_nmi_q;
  reg nmi_from_irq_q;
  reg [PC_W-1:0] stack1_q;
  reg [PC_W-1:0] stack2_q;
  reg [1:0] flag_sel_q;
  reg [1:0] nflags_q;
  reg [1:0] iflags_q;
  reg [1:0] mflags_q;
  reg irq_noswap_q;
  wire nmi_fall = nmi_prev & ~nmi_s;
  wire s1_fall = s1_p & ~s1;
  wire s2_edge = src2_edge_polarity ? (~s2_p & s2) : (s2_p & ~s2);
  wire s1_req = src1_level_select ? ~s1 : s1_latch_q;
  wire s3_req = ~s3;
  wire s4_req = ~s4;

  // ----------------------------------------------------------------
  // take decision at the instruction boundary
  // ----------------------------------------------------------------
  wire mask_ok = global_irq_enable & ~in_irq_q & ~in_nmi_q;
  wire take_nmi = instr_end & nmi_latch_q & ~in_nmi_q;
  wire take_1 = instr_end & ~take_nmi & mask_ok & s1_req;
  wire take_2 = instr_end & ~take_nmi & mask_ok & ~s1_req & s2_latch_q;
  wire take_3 = instr_end & ~take_nmi & mask_ok & ~s1_req & ~s2_latch_q & s3_req;
  wire take_4 = instr_end & ~take_nmi & mask_ok & ~s1_req & ~s2_latch_q & ~s3_req & s4_req;
  wire take_mask = take_1 | take_2 | take_3 | take_4;
  wire any_pending = nmi_latch_q | s1_req | s2_latch_q | s3_req | s4_req;
  // disabling write in progress: the flag pair stays normal
  // judged at acceptance, from the cycle index the core reports
  wire ldi_hazard = option_ldi_active && (option_ldi_cycle < `PIU_LDI_WINDOW);

  // ----------------------------------------------------------------
  // vector selection
  // ----------------------------------------------------------------
  reg [PC_W-1:0] take_vec;
  always @* begin
    take_vec = `PIU_VEC_SRC4;
    if (take_nmi) begin
      take_vec = `PIU_VEC_NMI;
    end else if (take_1) begin
      take_vec = `PIU_VEC_SRC1;
    end else if (take_2) begin
      take_vec = `PIU_VEC_SRC2;
    end else if (take_3) begin
      take_vec = `PIU_VEC_SRC3;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  reg aw_q;
  reg w_q;
  reg [7:0] awaddr_q;
  reg [7:0] wdata_q;
  reg wstrb0_q;
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_q & ~s_axi_bvalid;
  // a pending response blocks new requests: one write and one read at most
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_write = aw_q & w_q & ~s_axi_bvalid;
  // byte lane 0 must be strobed: a write without it is dropped, yet answered okay
  wire wr_option = do_write && (awaddr_q == `PIU_ADDR_OPTION) && wstrb0_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PIU_RESP_OKAY;
      option_q <= `PIU_OPTION_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == `PIU_ADDR_OPTION) ? `PIU_RESP_OKAY : `PIU_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_option) begin
        option_q <= wdata_q & `PIU_OPTION_MASK;
      end
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PIU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PIU_RESP_OKAY;
      case (s_axi_araddr)
        // option register is write-only and reads zero
        `PIU_ADDR_OPTION: s_axi_rdata <= 32'h0000_0000;
        `PIU_ADDR_STATUS: s_axi_rdata <= {25'h0, nmi_latch_q, s1_req, s2_latch_q, s3_req, s4_req,
                                          in_irq_q, in_nmi_q};
        `PIU_ADDR_CORE: s_axi_rdata <= {18'h0, flag_sel_q, stack1_q};
        `PIU_ADDR_EVENT: s_axi_rdata <= {{(32-(SW-1)){1'b0}}, event_flags_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `PIU_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // request latches and per-event flags
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      nmi_latch_q <= 1'b0;
      s1_latch_q <= 1'b0;
      s2_latch_q <= 1'b0;
      event_flags_q <= {(SW-1){1'b0}};
    end else begin
      // set wins over clear so an edge in the entry cycle is kept
      if (nmi_fall) begin
        nmi_latch_q <= 1'b1;
      end else if (take_nmi) begin
        nmi_latch_q <= 1'b0;
      end
      // only the first edge is stored until the routine starts
      if (!src1_level_select && s1_fall) begin
        s1_latch_q <= 1'b1;
      end else if (take_1 || src1_level_select) begin
        s1_latch_q <= 1'b0;
      end
      if (s2_edge) begin
        s2_latch_q <= 1'b1;
      end else if (take_2) begin
        s2_latch_q <= 1'b0;
      end
      // sticky per-line flags, cleared when their source is taken unless the line is still low
      event_flags_q <= (event_flags_q & ~{{EV_W{take_4}}, {EV_W{take_3}}, {EV_W{take_2}}, {EV_W{take_1}}})
                       | ~sync2_q[SW-1:1];
    end
  end

  // ----------------------------------------------------------------
  // entry / return sequencing
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      in_irq_q <= 1'b0;
      in_nmi_q <= 1'b0;
      nmi_from_irq_q <= 1'b0;
      irq_noswap_q <= 1'b0;
      stack1_q <= {PC_W{1'b0}};
      stack2_q <= {PC_W{1'b0}};
      flag_sel_q <= MODE_NORM;
      nflags_q <= 2'b00;
      iflags_q <= 2'b00;
      mflags_q <= 2'b00;
      irq_take <= 1'b0;
      vector_addr <= {PC_W{1'b0}};
      stack_push <= 1'b0;
      stack_push_pc <= {PC_W{1'b0}};
      stack_pop <= 1'b0;
    end else begin
      irq_take <= take_nmi | take_mask;
      stack_push <= take_nmi | take_mask;
      stack_pop <= 1'b0;
      // live flags write back into the selected pair
      case (flag_sel_q)
        MODE_NORM: nflags_q <= {carry_in, zero_in};
        MODE_IRQ: iflags_q <= {carry_in, zero_in};
        MODE_NMI: mflags_q <= {carry_in, zero_in};
        default: nflags_q <= {carry_in, zero_in};
      endcase
      if (take_nmi) begin
        in_nmi_q <= 1'b1;
        nmi_from_irq_q <= in_irq_q;
        stack2_q <= stack1_q;
        stack1_q <= core_pc;
        stack_push_pc <= core_pc;
        vector_addr <= take_vec;
        flag_sel_q <= MODE_NMI;
      end else if (take_mask) begin
        in_irq_q <= 1'b1;
        irq_noswap_q <= ldi_hazard;
        stack2_q <= stack1_q;
        stack1_q <= core_pc;
        stack_push_pc <= core_pc;
        // a late disabling write leaves the normal pair in use
        flag_sel_q <= ldi_hazard ? MODE_NORM : MODE_IRQ;
        vector_addr <= take_vec;
      end else if (return_from_irq_instr && (in_nmi_q || in_irq_q)) begin
        stack_pop <= 1'b1;
        stack_push_pc <= stack1_q;
        stack1_q <= stack2_q;
        if (in_nmi_q) begin
          in_nmi_q <= 1'b0;
          flag_sel_q <= nmi_from_irq_q ? (irq_noswap_q ? MODE_NORM : MODE_IRQ) : MODE_NORM;
        end else begin
          in_irq_q <= 1'b0;
          irq_noswap_q <= 1'b0;
          flag_sel_q <= MODE_NORM;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // flag pair selection
  // ----------------------------------------------------------------
  reg [1:0] live_pair;
  always @* begin
    case (flag_sel_q)
      MODE_NMI: live_pair = mflags_q;
      MODE_IRQ: live_pair = iflags_q;
      MODE_NORM: live_pair = nflags_q;
      default: live_pair = nflags_q;
    endcase
  end
  assign flag_set = flag_sel_q;
  assign carry_flag = live_pair[1];
  assign zero_flag = live_pair[0];

  // ----------------------------------------------------------------
  // wake-up
  // ----------------------------------------------------------------
  // the nmi counts as pending, yet still needs the global enable to wake
  always @(posedge aclk) begin
    if (!aresetn) begin
      wake_up <= 1'b0;
    end else begin
      wake_up <= core_sleeping & global_irq_enable & any_pending;
    end
  end
endmodule
`default_nettype wire

// >>> piu_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// core sequencer stand-in: boundaries on command
// ------------------------------------------------
module piu_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step_req,
  input wire logic ret_req,
  input wire logic irq_take,
  input wire logic [11:0] vector_addr,
  output logic instr_end,
  output logic return_from_irq_instr,
  output logic [11:0] core_pc
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      instr_end <= 1'b0;
      return_from_irq_instr <= 1'b0;
      core_pc <= 12'h000;
    end else begin
      instr_end <= step_req;
      return_from_irq_instr <= ret_req;
      // pc only moves at a boundary or on a take, so the pushed value is unambiguous
      if (irq_take) begin
        core_pc <= vector_addr;
      end else if (instr_end) begin
        core_pc <= core_pc + 12'h001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> piu_prioritized_interrupt_unit_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module piu_monitor #(
  parameter int PC_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_end,
  input wire logic return_from_irq_instr,
  input wire logic core_sleeping,
  input wire logic [PC_W-1:0] core_pc,
  input wire logic irq_take,
  input wire logic [PC_W-1:0] vector_addr,
  input wire logic stack_push,
  input wire logic [PC_W-1:0] stack_push_pc,
  input wire logic wake_up,
  input wire logic [1:0] flag_set,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_take_at_end: assert property (irq_take |-> $past(instr_end))
    else $error("request taken off an instruction boundary");
  a_take_pulse: assert property (irq_take |=> !irq_take)
    else $error("take pulse longer than one cycle");
  a_vec_fixed: assert property (irq_take |-> vector_addr inside {12'hffc, 12'hff6, 12'hff4, 12'hff2, 12'hff0})
    else $error("vector outside the fixed set");
  a_push_pc: assert property (irq_take |-> stack_push && stack_push_pc == $past(core_pc))
    else $error("entry did not push the boundary pc");
  a_nmi_flags: assert property (irq_take && vector_addr == 12'hffc |-> ##[0:1] flag_set == 2'b10)
    else $error("nmi entry without nmi flag pair");
  a_no_nest: assert property (flag_set == 2'b01 && instr_end |=> !irq_take || vector_addr == 12'hffc)
    else $error("maskable request nested in a maskable routine");
  a_wake_sleep: assert property (wake_up |-> $past(core_sleeping))
    else $error("wake raised while core awake");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before ready");
endmodule
bind piu_prioritized_interrupt_unit piu_monitor #(.PC_W(PC_W)) u_mon (
  .aclk(aclk), .aresetn(aresetn), .instr_end(instr_end), .return_from_irq_instr(return_from_irq_instr),
  .core_sleeping(core_sleeping), .core_pc(core_pc), .irq_take(irq_take), .vector_addr(vector_addr),
  .stack_push(stack_push), .stack_push_pc(stack_push_pc), .wake_up(wake_up), .flag_set(flag_set),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// >>> piu_prioritized_interrupt_unit_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "piu_consts.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module piu_prioritized_interrupt_unit_bench;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic nmi = 1, slp = 0, cin = 0, step = 0, ret = 0, lda = 0;
  logic [2:0] ldc = 0;
  logic [31:0] wd = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [3:0] e1 = 4'hf, e2 = 4'hf, e3 = 4'hf, e4 = 4'hf, ws = 4'hf;
  wire awr, wr, bv, arr, rv, ie, rfi, take, pop, wk, cf, zf;
  wire [1:0] br, rr, fs;
  wire [31:0] rd;
  wire [11:0] pc, vec;
  int failures = 0, check_count = 0, takes = 0;
  logic [11:0] last_vec = 0;
  always #25 aclk = ~aclk;
  always @(posedge aclk) if (take) begin takes <= takes + 1; last_vec <= vec; end
  piu_prioritized_interrupt_unit uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .nmi_pin(nmi), .src1_events(e1), .src2_events(e2), .src3_events(e3), .src4_events(e4),
    .instr_end(ie), .option_ldi_active(lda), .option_ldi_cycle(ldc), .return_from_irq_instr(rfi),
    .core_sleeping(slp), .core_pc(pc), .carry_in(cin), .zero_in(~cin), .irq_take(take), .vector_addr(vec),
    .stack_push(), .stack_push_pc(), .stack_pop(pop), .wake_up(wk), .carry_flag(cf), .zero_flag(zf),
    .flag_set(fs));
  piu_core_model core (.aclk(aclk), .aresetn(aresetn), .step_req(step), .ret_req(ret), .irq_take(take),
    .vector_addr(vec), .instr_end(ie), .return_from_irq_instr(rfi), .core_pc(pc));
  // ------------------------------------------------
  // bus and sequencer helpers
  // ------------------------------------------------
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wrt(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    int n;
    @(posedge aclk);
    awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; bry <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
      if (bv) begin `CHK(br, er) bry <= 0; break; end
    end
    if (n == 40) begin failures++; end_sim(); end
  endtask
  task automatic rdt(input [7:0] a, input [31:0] ed, input [1:0] er);
    int n;
    @(posedge aclk);
    ara <= a; arv <= 1; rry <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arv && arr) arv <= 0;
      if (rv) begin `CHK(rr, er) if (er == `PIU_RESP_OKAY) `CHK(rd, ed) rry <= 0; break; end
    end
    if (n == 40) begin failures++; end_sim(); end
  endtask
  // waits out the two-stage sync plus edge detect on request lines
  task automatic settle(); repeat (5) @(posedge aclk); endtask
  task automatic ins(input logic et, input logic [11:0] ev);
    int t0;
    t0 = takes;
    @(posedge aclk); step <= 1; cin <= ~cin;
    @(posedge aclk); step <= 0;
    repeat (3) @(posedge aclk);
    `CHK(takes != t0, et)
    if (et) `CHK(last_vec, ev)
  endtask
  task automatic retn();
    @(posedge aclk); ret <= 1; @(posedge aclk); ret <= 0;
    repeat (2) @(posedge aclk); `CHK(pop, 1'b1)
    @(posedge aclk);
  endtask
  task automatic sleep_wake(input logic ew);
    @(posedge aclk); slp <= 1; repeat (3) @(posedge aclk); `CHK(wk, ew) slp <= 0;
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_regs();
    rdt(`PIU_ADDR_OPTION, 32'h0, `PIU_RESP_OKAY);
    rdt(8'h40, 32'h0, `PIU_RESP_SLVERR);
    wrt(8'h40, 32'h10, 4'hf, `PIU_RESP_SLVERR);
    wrt(`PIU_ADDR_OPTION, 32'h10, 4'he, `PIU_RESP_OKAY);
    e3 <= 4'he; settle();
    ins(0, 12'h0);
    sleep_wake(0);
  endtask
  task automatic t_nmi();
    nmi <= 0; settle();
    sleep_wake(0);
    ins(1, `PIU_VEC_NMI);
    `CHK(fs, 2'b10)
    ins(0, 12'h0);
    retn(); `CHK(fs, 2'b00)
    nmi <= 1;
  endtask
  task automatic t_prio();
    wrt(`PIU_ADDR_OPTION, 32'h8f, 4'hf, `PIU_RESP_OKAY); ins(0, 12'h0);
    wrt(`PIU_ADDR_OPTION, 32'h9f, 4'hf, `PIU_RESP_OKAY);
    e1 <= 4'hb; e4 <= 4'h7; settle();
    sleep_wake(1);
    ins(1, `PIU_VEC_SRC1);
    `CHK(fs, 2'b01)
    ins(0, 12'h0);
    nmi <= 0; settle(); ins(1, `PIU_VEC_NMI);
    retn(); `CHK(fs, 2'b01)
    nmi <= 1; retn(); `CHK(fs, 2'b00)
    ins(1, `PIU_VEC_SRC3); retn();
    e3 <= 4'hf; settle(); ins(1, `PIU_VEC_SRC4); retn();
    e4 <= 4'hf; e1 <= 4'hf; settle(); ins(0, 12'h0);
  endtask
  task automatic t_modes();
    wrt(`PIU_ADDR_OPTION, 32'h30, 4'hf, `PIU_RESP_OKAY);
    e2 <= 4'he; settle(); ins(0, 12'h0);
    e2 <= 4'hf; settle(); ins(1, `PIU_VEC_SRC2); retn();
    wrt(`PIU_ADDR_OPTION, 32'h50, 4'hf, `PIU_RESP_OKAY);
    e1 <= 4'hd; settle(); ins(1, `PIU_VEC_SRC1); retn();
    ins(1, `PIU_VEC_SRC1); retn();
    e1 <= 4'hf; settle(); ins(0, 12'h0);
  endtask
  task automatic t_ldi();
    e1 <= 4'he; lda <= 1; ldc <= 3'h1; settle();
    ins(1, `PIU_VEC_SRC1); `CHK(fs, 2'b00)
    retn(); ldc <= 3'h3;
    ins(1, `PIU_VEC_SRC1); `CHK(fs, 2'b01)
    retn(); lda <= 0; e1 <= 4'hf; settle();
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_nmi();
    t_prio();
    t_modes();
    t_ldi();
    end_sim();
  end
endmodule
`default_nettype wire
